// ### src/emsq_regs.sv
// status flags, queue pointers and bus slave of the MAC status block
`timescale 1ns/100ps
`default_nettype none
`include "emsq_defs.svh"

module emsq_regs (
  input  wire logic                  clk,          // 200 MHz system clock
  input  wire logic                  sys_rst,      // sync reset, high
  input  wire logic                  hsel,         // slave select
  input  wire logic [31:0]           haddr,        // byte address
  input  wire logic [1:0]            htrans,       // transfer type
  input  wire logic                  hwrite,       // write when high
  input  wire logic [2:0]            hsize,        // word only
  input  wire logic [31:0]           hwdata,       // write data
  input  wire logic                  hready,       // bus ready
  output logic      [31:0]           hrdata,       // read data
  output logic                       hreadyout,    // slave ready
  output logic                       hresp,        // always OKAY
  input  wire logic                  mdio_in,      // management data pin
  input  wire logic                  col,          // PHY collision pin
  input  wire logic                  tx_clk,       // PHY transmit clock pin
  input  wire logic                  mgmt_busy,    // management running
  input  wire logic                  mgmt_done,    // management finished
  input  wire logic                  transmit_active, // transmitter live
  input  wire logic                  pause_rx,     // valid pause received
  input  wire logic                  pause_zero,   // pause time hit zero
  input  var  emsq_pkg::emsq_tx_evt_s tx_evt,      // transmit events
  input  var  emsq_pkg::emsq_rx_evt_s rx_evt,      // receive events
  output logic                       ignore_rx_checksum, // accept bad FCS
  output logic [31:0]                rx_qptr,      // current rx descriptor
  output logic [31:0]                tx_qptr,      // current tx descriptor
  output logic                       tx_force_bad_crc, // corrupt FCS pulse
  output logic                       tx_er,        // transmit error pulse
  output logic                       tx_stop,      // stop frame pulse
  output logic                       rx_reclaim,   // recover buffer pulse
  output logic                       rx_retry      // retry at next frame
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] mdio_sync;
  logic [1:0] col_sync;
  logic [1:0] txc_sync;
  logic       txc_prev;

  // two flops each; only the second stage is looked at, except the transmit clock, whose edge also uses a third flop
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mdio_sync <= 2'h0;
      col_sync  <= 2'h0;
      txc_sync  <= 2'h0;
      txc_prev  <= 1'b0;
    end else begin
      mdio_sync <= {mdio_sync[0], mdio_in};
      col_sync  <= {col_sync[0], col};
      txc_sync  <= {txc_sync[0], tx_clk};
      txc_prev  <= txc_sync[1];
    end
  end

  // collision is judged at the link clock edge, as the PHY presents it
  wire txc_rise = txc_sync[1] & ~txc_prev;
  wire col_hit  = txc_rise & col_sync[1];

  // ------------------------------------------------------------
  // bus address phase
  // ------------------------------------------------------------
  emsq_pkg::emsq_bus_st_e state;
  logic [31:0]            wr_addr;

  wire take    = hsel & htrans[1] & hready;
  wire take_rd = take & ~hwrite;
  wire take_wr = take & hwrite;

  // one wait state on writes lets hwdata land before any later read
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state     <= emsq_pkg::EMSQ_ST_IDLE;
      wr_addr   <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      unique case (state)
        emsq_pkg::EMSQ_ST_IDLE: begin
          if (take_wr) begin
            state     <= emsq_pkg::EMSQ_ST_WRITE;
            wr_addr   <= haddr;
            hreadyout <= 1'b0;
          end
        end
        emsq_pkg::EMSQ_ST_WRITE: begin
          state     <= emsq_pkg::EMSQ_ST_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  wire wr_now = (state == emsq_pkg::EMSQ_ST_WRITE);

  // write decode, applied in the first data-phase cycle
  wire wr_ncfg = wr_now & (wr_addr == `EMSQ_ADDR_NCFG);
  wire wr_tsr  = wr_now & (wr_addr == `EMSQ_ADDR_TSR);
  wire wr_rqp  = wr_now & (wr_addr == `EMSQ_ADDR_RQP);
  wire wr_rsr  = wr_now & (wr_addr == `EMSQ_ADDR_RSR);
  // transmit pointer writes during transmission are dropped silently
  wire wr_tqp  = wr_now & (wr_addr == `EMSQ_ADDR_TQP)
                 & ~transmit_active;

  // read decode on the address phase
  wire rd_isr  = take_rd & (haddr == `EMSQ_ADDR_ISR);

  // ------------------------------------------------------------
  // configuration
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ignore_rx_checksum <= 1'(`EMSQ_NCFG_RESET >> `EMSQ_NCFG_IGN_BIT);
    end else if (wr_ncfg) begin
      ignore_rx_checksum <= hwdata[`EMSQ_NCFG_IGN_BIT];
    end
  end

  // ------------------------------------------------------------
  // event decode
  // ------------------------------------------------------------
  wire tx_under = tx_evt.dma_late | tx_evt.hresp_err
                  | tx_evt.used_mid;
  wire rx_ovr   = rx_evt.dma_late | rx_evt.hresp_err;
  wire bus_err  = tx_evt.hresp_err | rx_evt.hresp_err;

  // transmit flags: underrun, complete, exhausted, retry, collision, owned
  logic [5:0] tsr;
  wire  [5:0] tsr_set = {tx_under,
                         tx_evt.complete,
                         tx_evt.exhausted,
                         tx_evt.retry_limit,
                         col_hit,
                         tx_evt.owned_desc};
  wire  [5:0] tsr_clr = wr_tsr ? {hwdata[6:4], hwdata[2:0]} : 6'h00;

  // receive flags: overrun, frame received, buffer not available
  logic [2:0] rsr;
  wire  [2:0] rsr_set = {rx_ovr,
                         rx_evt.stored,
                         rx_evt.owned_desc};
  wire  [2:0] rsr_clr = wr_rsr ? hwdata[2:0] : 3'h0;

  // write-one-to-clear; a set in the same cycle wins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tsr <= 6'h00;
      rsr <= 3'h0;
    end else begin
      tsr <= (tsr & ~tsr_clr) | tsr_set;
      rsr <= (rsr & ~rsr_clr) | rsr_set;
    end
  end

  // interrupt flags, bits 13..10 and 7..0 of the register
  logic [11:0] isr;
  wire  [11:0] isr_set = {pause_zero,
                          pause_rx,
                          bus_err,
                          rx_ovr,
                          tx_evt.complete,
                          tx_evt.exhausted,
                          tx_evt.retry_limit,
                          tx_under | wr_tqp,
                          tx_evt.owned_desc,
                          rx_evt.owned_desc,
                          rx_evt.stored,
                          mgmt_done};

  // clear on read, events arriving with the read survive
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      isr <= 12'h000;
    end else begin
      isr <= (rd_isr ? 12'h000 : isr) | isr_set;
    end
  end

  // ------------------------------------------------------------
  // error side effects to the MAC core
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_force_bad_crc <= 1'b0;
      tx_er            <= 1'b0;
      tx_stop          <= 1'b0;
      rx_reclaim       <= 1'b0;
    end else begin
      tx_force_bad_crc <= tx_under | tx_evt.exhausted;
      tx_er            <= tx_evt.exhausted;
      tx_stop          <= tx_evt.exhausted;
      rx_reclaim       <= rx_ovr;
    end
  end

  // retry request holds until a valid descriptor is found
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_retry <= 1'b0;
    end else if (rx_evt.owned_desc) begin
      rx_retry <= 1'b1;
    end else if (rx_evt.desc_ok) begin
      rx_retry <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // queue pointers
  // ------------------------------------------------------------
  logic [31:0] rq_start;
  logic [31:0] tq_start;
  logic [31:0] tq_frame;
  logic [9:0]  rq_idx;
  logic [9:0]  tq_idx;

  // wrap after 1024 buffers or at a descriptor marked wrap
  wire rq_back = rx_evt.wrap | (rq_idx == `EMSQ_QP_LAST_IDX);
  wire tq_back = tx_evt.wrap | (tq_idx == `EMSQ_QP_LAST_IDX);
  wire [31:0] rq_step = rx_qptr + `EMSQ_DESC_STEP;
  wire [31:0] tq_step = tx_qptr + `EMSQ_DESC_STEP;
  wire [31:0] tq_next = tq_back ? tq_start : tq_step;

  // receive pointer tracks the descriptor in use
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rq_start <= `EMSQ_QP_RESET;
      rx_qptr  <= `EMSQ_QP_RESET;
      rq_idx   <= 10'h000;
    end else if (wr_rqp) begin
      rq_start <= {hwdata[31:2], 2'b00};
      rx_qptr  <= {hwdata[31:2], 2'b00};
      rq_idx   <= 10'h000;
    end else if (rx_evt.buf_used) begin
      rx_qptr  <= rq_back ? rq_start : rq_step;
      rq_idx   <= rq_back ? 10'h000 : rq_idx + 10'h001;
    end
  end

  // transmit pointer; the reported copy moves only at frame end or on a pointer write
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tq_start <= `EMSQ_QP_RESET;
      tx_qptr  <= `EMSQ_QP_RESET;
      tq_frame <= `EMSQ_QP_RESET;
      tq_idx   <= 10'h000;
    end else if (wr_tqp) begin
      tq_start <= {hwdata[31:2], 2'b00};
      tx_qptr  <= {hwdata[31:2], 2'b00};
      tq_frame <= {hwdata[31:2], 2'b00};
      tq_idx   <= 10'h000;
    end else begin
      if (tx_evt.buf_used) begin
        tx_qptr <= tq_next;
        tq_idx  <= tq_back ? 10'h000 : tq_idx + 10'h001;
      end
      if (tx_evt.complete) begin
        tq_frame <= tx_evt.buf_used ? tq_next : tx_qptr;
      end
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  wire [31:0] nsr_val = {29'h0, ~mgmt_busy,
                         mdio_sync[1], 1'b0};
  wire [31:0] tsr_val = {25'h0, tsr[5:3], transmit_active,
                         tsr[2:0]};
  wire [31:0] isr_val = {18'h0, isr[11:8], 2'b00, isr[7:0]};
  wire [31:0] ncfg_val = {12'h0, ignore_rx_checksum, 19'h0};

  logic [31:0] rd_mux;

  // unmapped addresses read as zero
  always_comb begin
    unique case (haddr)
      `EMSQ_ADDR_NCFG: rd_mux = ncfg_val;
      `EMSQ_ADDR_NSR:  rd_mux = nsr_val;
      `EMSQ_ADDR_TSR:  rd_mux = tsr_val;
      `EMSQ_ADDR_RQP:  rd_mux = rx_qptr;
      `EMSQ_ADDR_TQP:  rd_mux = tq_frame;
      `EMSQ_ADDR_RSR:  rd_mux = {29'h0, rsr};
      `EMSQ_ADDR_ISR:  rd_mux = isr_val;
      default:         rd_mux = 32'h00000000;
    endcase
  end

  // sampled at the address phase so the clearing read sees the old flags
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hrdata <= 32'h00000000;
    end else if (take_rd) begin
      hrdata <= rd_mux;
    end
  end

endmodule
`default_nettype wire

// ### src/emsq_defs.svh
// register map, field positions and reset values of the status and queue block
// Operation
// - ignore-checksum bit set accepts bad-CRC frames, no FCS error counting; normally 0
// - network status bit returns the synchronised management data input level
// - idle bit reads 0 while management runs, 1 when idle or finished
// - status flags clear on writing 1; writes never set a flag
// - transmit owned-descriptor flag sets when a used descriptor is fetched
// - collision flag sets when the PHY collision input is high at a rising edge of the transmit clock
// - transmit-active bit is live status, not cleared by writing
// - buffers out mid-frame: stop, bad FCS, tx_er, exhausted flag
// - transmit-complete flag sets each time a frame is fully sent
// - late data, no grant, bus error or mid-frame used bit: underrun, bad CRC
// - queue pointers load start, step per buffer, wrap at 1024 or wrap bit
// - receive pointer reads back the descriptor currently accessed
// - transmit pointer accepts writes only while transmit is inactive
// - transmit pointer reads first descriptor of current or next frame
// - receive owned descriptor sets not-available each failure, retries next frame
// - frame-received flag sets once frames are stored in memory
// - receive store failure sets overrun and reclaims the buffer
// - interrupt flags clear on read; management done and receive done set
// - receive owned-descriptor interrupt flag sets on a used receive fetch
// - underrun interrupt also sets on mid-frame used bit or pointer write
// - flags for transmit done, overrun, bus error, pause frame, pause zero
`ifndef EMSQ_DEFS_SVH
`define EMSQ_DEFS_SVH

`define EMSQ_ADDR_NCFG      32'hFFFC4004
`define EMSQ_ADDR_NSR       32'hFFFC4008
`define EMSQ_ADDR_TSR       32'hFFFC4014
`define EMSQ_ADDR_RQP       32'hFFFC4018
`define EMSQ_ADDR_TQP       32'hFFFC401C
`define EMSQ_ADDR_RSR       32'hFFFC4020
`define EMSQ_ADDR_ISR       32'hFFFC4024

`define EMSQ_NCFG_IGN_BIT   19
`define EMSQ_NCFG_RESET     32'h00000000
`define EMSQ_QP_RESET       32'h00000000
`define EMSQ_DESC_STEP      32'h00000008
`define EMSQ_QP_LAST_IDX    10'h3FF
`define EMSQ_WR_WAIT_CYCLES 1

`endif

// ### src/emsq_pkg.sv
// types shared by the status and queue block
package emsq_pkg;

  // transmit side events from the MAC core, one-cycle pulses
  typedef struct packed {
    logic owned_desc;    // descriptor fetched with used bit set
    logic retry_limit;   // retry limit exceeded
    logic exhausted;     // buffers ran out mid frame
    logic complete;      // frame fully transmitted
    logic dma_late;      // data not fetched in time / no grant
    logic hresp_err;     // bus error seen by transmit DMA
    logic used_mid;      // used bit read mid frame
    logic buf_used;      // one buffer consumed
    logic wrap;          // consumed buffer had wrap bit set
  } emsq_tx_evt_s;

  // receive side events from the MAC core, one-cycle pulses
  typedef struct packed {
    logic owned_desc;    // descriptor still owned by processor
    logic stored;        // frame written to memory
    logic dma_late;      // no grant in time
    logic hresp_err;     // bus error seen by receive DMA
    logic desc_ok;       // a valid descriptor was obtained
    logic buf_used;      // one buffer consumed
    logic wrap;          // consumed buffer had wrap bit set
  } emsq_rx_evt_s;

  // bus slave data-phase state
  typedef enum logic [1:0] {
    EMSQ_ST_IDLE  = 2'b01,
    EMSQ_ST_WRITE = 2'b10
  } emsq_bus_st_e;

endpackage

// ### tb/emsq_monitor.sv
// checker watching the ports of the status and queue block
`timescale 1ns/100ps
`default_nettype none
`include "emsq_defs.svh"
module emsq_monitor (
  input wire logic                   clk,                // system clock
  input wire logic                   sys_rst,            // sync reset
  input wire logic                   hsel,               // slave select
  input wire logic [31:0]            haddr,              // address
  input wire logic [1:0]             htrans,             // transfer type
  input wire logic                   hwrite,             // write
  input wire logic                   hready,             // bus ready
  input wire logic [31:0]            hrdata,             // read data
  input wire logic                   hreadyout,          // slave ready
  input wire logic                   mgmt_busy,          // mgmt running
  input wire logic                   transmit_active,    // live transmit
  input var  emsq_pkg::emsq_tx_evt_s tx_evt,             // tx events
  input var  emsq_pkg::emsq_rx_evt_s rx_evt,             // rx events
  input wire logic                   ignore_rx_checksum, // config bit
  input wire logic [31:0]            rx_qptr,            // rx pointer
  input wire logic [31:0]            tx_qptr,            // tx pointer
  input wire logic                   tx_force_bad_crc,   // bad crc
  input wire logic                   tx_er,              // tx error
  input wire logic                   tx_stop,            // tx stop
  input wire logic                   rx_reclaim,         // reclaim
  input wire logic                   rx_retry            // retry
);
  // -------------------------------------------------------------------
  // properties
  // -------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // read address phase taken; data follows on the next edge
  wire logic rd_go = hsel && htrans[1] && hready && !hwrite;
  AST_EXHAUST:
    assert property (tx_evt.exhausted |=> tx_er && tx_stop && tx_force_bad_crc)
    else $error("exhausted event without error, stop or bad crc");
  AST_BAD_CRC:
    assert property ((tx_evt.dma_late || tx_evt.hresp_err || tx_evt.used_mid)
      |=> tx_force_bad_crc) else $error("underrun cause without bad crc");
  AST_RECLAIM:
    assert property ((rx_evt.dma_late || rx_evt.hresp_err) |=> rx_reclaim)
    else $error("store failure without reclaim");
  AST_RETRY_SET:
    assert property (rx_evt.owned_desc |=> rx_retry)
    else $error("owned receive descriptor without retry");
  AST_RETRY_END:
    assert property (rx_evt.desc_ok && !rx_evt.owned_desc |=> !rx_retry)
    else $error("retry still up after a valid descriptor");
  AST_RQP_HOLD:
    assert property (hreadyout && !rx_evt.buf_used |=> $stable(rx_qptr))
    else $error("receive pointer moved without cause");
  AST_TQP_LOCK:
    assert property (!hreadyout && transmit_active && !tx_evt.buf_used
      |=> $stable(tx_qptr)) else $error("transmit pointer written while live");
  AST_IGN_HOLD:
    assert property (hreadyout |=> $stable(ignore_rx_checksum))
    else $error("checksum option changed without a write");
  AST_TGO_READ:
    assert property (rd_go && haddr == `EMSQ_ADDR_TSR
      |=> hrdata[3] == $past(transmit_active)) else $error("live bit wrong");
  AST_IDLE_READ:
    assert property (rd_go && haddr == `EMSQ_ADDR_NSR
      |=> hrdata[2] == !$past(mgmt_busy)) else $error("idle bit wrong");
endmodule
bind emsq_regs emsq_monitor i_emsq_monitor (.clk, .sys_rst, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hrdata, .hreadyout, .mgmt_busy, .transmit_active,
  .tx_evt, .rx_evt, .ignore_rx_checksum, .rx_qptr, .tx_qptr, .tx_force_bad_crc,
  .tx_er, .tx_stop, .rx_reclaim, .rx_retry);
`default_nettype wire

// ### tb/emsq_phy_model.sv
// behavioural PHY: management data, collision and transmit clock pins
`timescale 1ns/100ps
`default_nettype none
module emsq_phy_model (
  input  wire logic run,     // a frame is on the wire
  input  wire logic col_req, // collision wanted
  input  wire logic mdo_en,  // PHY drives management data
  input  wire logic mdo_val, // driven level
  output logic      tx_clk,  // transmit clock pin
  output logic      col,     // collision pin
  output wire logic mdio_in  // management data pin
);
  // released line floats to the pull-up level
  assign mdio_in = mdo_en ? mdo_val : 1'b1;
  // collision only within a frame
  assign col = col_req & run;
  // clock stands still low between frames, 48 ns period inside
  initial begin
    tx_clk = 1'b0;
    forever begin
      #24;
      tx_clk = run ? ~tx_clk : 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### tb/emsq_regs_bench.sv
// self-checking bench of the status and queue block with a register model
`timescale 1ns/100ps
`default_nettype none
`include "emsq_defs.svh"
module emsq_regs_bench;
  logic clk, sys_rst, hsel, hwrite, hready, hresp, mgmt_busy, mgmt_done;
  logic transmit_active, pause_rx, pause_zero, run, col_req, mdo_en, mdo_val;
  logic tx_clk, col, mdio_in, ignore_rx_checksum, tx_force_bad_crc, tx_er;
  logic tx_stop, rx_reclaim, rx_retry, hreadyout, e_ign, e_rty;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rx_qptr, tx_qptr, d;
  logic [31:0] e_tsr, e_rsr, e_isr, r_st, r_p, t_st, t_p, t_rep;
  emsq_pkg::emsq_tx_evt_s tx_evt;
  emsq_pkg::emsq_rx_evt_s rx_evt;
  int failures, checked, r_n, t_n, seed, i;
  logic [31:0] addrs[9] = '{32'hFFFC4000, `EMSQ_ADDR_NCFG, `EMSQ_ADDR_NSR,
    `EMSQ_ADDR_TSR, `EMSQ_ADDR_RQP, `EMSQ_ADDR_TQP, `EMSQ_ADDR_RSR,
    `EMSQ_ADDR_ISR, 32'hFFFC4028};
  assign hready = hreadyout;
  emsq_regs i_emsq_regs (.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .mdio_in, .col,
    .tx_clk, .mgmt_busy, .mgmt_done, .transmit_active, .pause_rx, .pause_zero,
    .tx_evt, .rx_evt, .ignore_rx_checksum, .rx_qptr, .tx_qptr,
    .tx_force_bad_crc, .tx_er, .tx_stop, .rx_reclaim, .rx_retry);
  emsq_phy_model i_emsq_phy_model (.run, .col_req, .mdo_en, .mdo_val, .tx_clk,
    .col, .mdio_in);
  // -------------------------------------------------------------------
  // clock, comparisons and bus master
  // -------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic cmp(input logic [63:0] g, input logic [63:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // address phase held until ready, then data phase held until ready
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    // only the watchdog ends a wait that never sees ready
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  // -------------------------------------------------------------------
  // register model
  // -------------------------------------------------------------------
  function automatic logic [31:0] expv(input logic [31:0] a);
    case (a)
      `EMSQ_ADDR_NCFG: expv = {12'h000, e_ign, 19'h00000};
      `EMSQ_ADDR_NSR:  expv = {29'h0, !mgmt_busy, mdio_in, 1'b0};
      `EMSQ_ADDR_TSR:  expv = e_tsr | {28'h0, transmit_active, 3'h0};
      `EMSQ_ADDR_RQP:  expv = r_p;
      `EMSQ_ADDR_TQP:  expv = t_rep;
      `EMSQ_ADDR_RSR:  expv = e_rsr;
      `EMSQ_ADDR_ISR:  expv = e_isr;
      default:         expv = 32'h00000000;
    endcase
  endfunction
  task automatic rdc(input logic [31:0] a);
    logic [31:0] r;
    logic [31:0] e;
    e = expv(a);
    bus(1'b0, a, 32'h00000000, r);
    cmp(r, e);
    if (a == `EMSQ_ADDR_ISR) e_isr = 32'h00000000;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] wd);
    logic [31:0] r;
    bus(1'b1, a, wd, r);
    if (a == `EMSQ_ADDR_NCFG) e_ign = wd[19];
    if (a == `EMSQ_ADDR_TSR) e_tsr &= ~wd;
    if (a == `EMSQ_ADDR_RSR) e_rsr &= ~wd;
    if (a == `EMSQ_ADDR_RQP)
      {r_st, r_p, r_n} = {wd & ~32'h3, wd & ~32'h3, 32'd0};
    if (a == `EMSQ_ADDR_TQP && !transmit_active) begin
      {t_st, t_p, t_rep, t_n} = {{3{wd & ~32'h3}}, 32'd0};
      e_isr[4] = 1'b1;
    end
  endtask
  // descriptor step, back to start on wrap bit or after 1024 buffers
  task automatic step(inout logic [31:0] p, input logic [31:0] s, inout int n,
                      input logic w);
    p = (w || n == 1023) ? s : p + `EMSQ_DESC_STEP;
    n = (w || n == 1023) ? 0 : n + 1;
  endtask
  task automatic tx(input emsq_pkg::emsq_tx_evt_s v);
    logic u;
    u = v.dma_late | v.hresp_err | v.used_mid;
    @(posedge clk) tx_evt <= v;
    @(posedge clk) tx_evt <= '0;
    e_tsr |= {25'h0, u, v.complete, v.exhausted, 1'b0, v.retry_limit, 2'b0}
      | v.owned_desc;
    e_isr |= {20'h0, v.hresp_err, 3'h0, v.complete, v.exhausted, v.retry_limit,
      u, v.owned_desc, 3'h0};
    if (v.buf_used) step(t_p, t_st, t_n, v.wrap);
    if (v.complete) t_rep = t_p;
  endtask
  task automatic rx(input emsq_pkg::emsq_rx_evt_s v);
    logic o;
    o = v.dma_late | v.hresp_err;
    @(posedge clk) rx_evt <= v;
    @(posedge clk) rx_evt <= '0;
    e_rsr |= {29'h0, o, v.stored, v.owned_desc};
    e_isr |= {20'h0, v.hresp_err, o, 7'h0, v.owned_desc, v.stored, 1'b0};
    e_rty = v.owned_desc | (e_rty & ~v.desc_ok);
    if (v.buf_used) step(r_p, r_st, r_n, v.wrap);
  endtask
  task automatic pins();
    @(negedge clk);
    cmp({rx_qptr, tx_qptr}, {r_p, t_p});
    cmp({rx_retry, ignore_rx_checksum, hresp}, {e_rty, e_ign, 1'b0});
  endtask
  task automatic report_and_stop();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // watchdog: the run needs a few thousand cycles
  initial begin
    #200000;
    failures++;
    report_and_stop();
  end
  // -------------------------------------------------------------------
  // tests
  // -------------------------------------------------------------------
  initial begin
    {sys_rst, hsel, hwrite, htrans, hsize, haddr, hwdata} = {1'b1, 39'h0, 32'h0};
    {mgmt_busy, mgmt_done, transmit_active, pause_rx, pause_zero} = 5'h00;
    {run, col_req, mdo_en, mdo_val, tx_evt, rx_evt} = '0;
    {e_ign, e_rty, e_tsr, e_rsr, e_isr, r_st, r_p, t_st, t_p, t_rep} = '0;
    {r_n, t_n, failures, checked, seed} = {32'd0, 32'd0, 64'd0, 32'd46};
    hsize = 3'b010;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (addrs[k]) rdc(addrs[k]);
    $display("test reset values done");
    wr(`EMSQ_ADDR_NCFG, 32'hFFFFFFFF);
    wr(32'hFFFC4000, 32'hFFFFFFFF);
    rdc(`EMSQ_ADDR_NCFG);
    rdc(32'hFFFC4000);
    pins();
    @(posedge clk) {mgmt_busy, mdo_en, mdo_val} <= 3'b110;
    repeat (4) @(posedge clk);
    rdc(`EMSQ_ADDR_NSR);
    @(posedge clk) {mgmt_busy, mdo_en} <= 2'b00;
    wr(`EMSQ_ADDR_NCFG, 32'h00000000);
    rdc(`EMSQ_ADDR_NSR);
    $display("test config and network status done");
    for (i = 0; i < 9; i++) begin
      tx(emsq_pkg::emsq_tx_evt_s'(9'h001 << i));
      rdc(`EMSQ_ADDR_TSR);
      rdc(`EMSQ_ADDR_ISR);
      wr(`EMSQ_ADDR_TSR, $random(seed));
      rdc(`EMSQ_ADDR_TSR);
    end
    @(posedge clk) {run, col_req} <= 2'b11;
    repeat (30) @(posedge clk);
    {run, col_req, transmit_active} <= 3'b001;
    e_tsr[1] = 1'b1; // collision seen while the frame ran
    wr(`EMSQ_ADDR_TSR, 32'h00000008);
    rdc(`EMSQ_ADDR_TSR);
    wr(`EMSQ_ADDR_TSR, 32'hFFFFFFFF);
    rdc(`EMSQ_ADDR_TSR);
    $display("test transmit status done");
    d = $random(seed) & 32'hFFFFFFF8;
    wr(`EMSQ_ADDR_TQP, d);
    rdc(`EMSQ_ADDR_TQP);
    rdc(`EMSQ_ADDR_ISR);
    @(posedge clk) transmit_active <= 1'b0;
    wr(`EMSQ_ADDR_TQP, d);
    rdc(`EMSQ_ADDR_ISR);
    repeat (3) tx(emsq_pkg::emsq_tx_evt_s'(9'h002));
    rdc(`EMSQ_ADDR_TQP);
    pins();
    tx(emsq_pkg::emsq_tx_evt_s'(9'h020));
    rdc(`EMSQ_ADDR_TQP);
    wr(`EMSQ_ADDR_RQP, $random(seed) & 32'hFFFFFFFB);
    repeat (2) rx(emsq_pkg::emsq_rx_evt_s'(7'h02));
    rdc(`EMSQ_ADDR_RQP);
    rx(emsq_pkg::emsq_rx_evt_s'(7'h03));
    rdc(`EMSQ_ADDR_RQP);
    repeat (1024) rx(emsq_pkg::emsq_rx_evt_s'(7'h02));
    pins();
    rdc(`EMSQ_ADDR_RQP);
    $display("test queue pointers done");
    // frames are found from the status flags, not the moving pointer
    for (i = 6; i >= 0; i--) begin
      rx(emsq_pkg::emsq_rx_evt_s'(7'h01 << i));
      pins();
      rdc(`EMSQ_ADDR_RSR);
      rdc(`EMSQ_ADDR_ISR);
    end
    wr(`EMSQ_ADDR_RSR, 32'hFFFFFFFF);
    rdc(`EMSQ_ADDR_RSR);
    for (i = 0; i < 3; i++) begin
      @(posedge clk) {pause_zero, pause_rx, mgmt_done} <= 3'b001 << i;
      @(posedge clk) {pause_zero, pause_rx, mgmt_done} <= 3'b000;
      e_isr |= {18'h0, i == 2, i == 1, 11'h0, i == 0};
      rdc(`EMSQ_ADDR_ISR);
      rdc(`EMSQ_ADDR_ISR);
    end
    $display("test receive and interrupt status done");
    report_and_stop();
  end
endmodule
`default_nettype wire
